/* File: logic/wrap_timer_pkg.sv */
// Package with register map, field layout and types of the modulo timer
package wrap_timer_pkg;
  localparam int DATA_W = 8;
  localparam logic [3:0] OFF_STATUS = 4'h0;
  localparam logic [3:0] OFF_CLOCK = 4'h4;
  localparam logic [3:0] OFF_COUNT = 4'h8;
  localparam logic [3:0] OFF_WRAP = 4'hC;
  localparam int BIT_OVERFLOW = 7;
  localparam int BIT_IRQ_EN = 6;
  localparam int BIT_CLEAR = 5;
  localparam int BIT_HALT = 4;
  localparam int SRC_HI = 5;
  localparam int SRC_LO = 4;
  localparam int PS_HI = 3;
  localparam int PS_LO = 0;
  localparam logic [3:0] PS_MAX = 4'h8;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] WRAP_RESET = 8'h00;
  localparam logic [7:0] COUNT_TOP = 8'hFF;
  localparam logic HALT_RESET = 1'b1;
  localparam logic IRQ_EN_RESET = 1'b0;
  localparam logic [3:0] PS_RESET = 4'h0;

  typedef enum logic [1:0] {
    SRC_BUS = 2'b00,
    SRC_FIXED = 2'b01,
    SRC_EXT_FALL = 2'b10,
    SRC_EXT_RISE = 2'b11
  } source_type;

  typedef struct packed {
    source_type source_select;
    logic [3:0] prescale_select;
  } clock_cfg_type;

  localparam clock_cfg_type CLOCK_CFG_RESET = '{source_select: SRC_BUS, prescale_select: PS_RESET};
endpackage

/* File: logic/wrap_timer.sv */
// Modulo timer with prescaler, selectable source and APB registers
// Functional notes
// - Debug mode suspends counting, value held
// - External count input synchronised to bus clock
// - Four 8-bit software registers
// - Overflow flag sets on wrap to zero
// - Flag clears by read-then-write-zero sequence
// - Counter clear or wrap write clears flag; a wrap in the same cycle sets it instead
// - Enabled flag raises interrupt request
// - Clear command zeroes count, reads zero
// - Halt bit freezes count, reset sets it
// - Unused bits read as zero
// - Source select picks prescaler input
// - Source change keeps the count
// - Prescale divides by power of two
// - Prescale change keeps the count
// - Count up to wrap value, then zero
// - Wrap value zero gives free running
// - Overflow during sequence restarts clearing
// - Count register read-only, reset clears
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module wrap_timer #(
  parameter int ADDR_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_count_input,
  input wire logic fixed_freq_clock,
  input wire logic debug_active,
  output logic overflow_irq
);

  if (ADDR_W < 4) begin : gen_addr_check
    $error("ADDR_W must be at least 4");
  end

  logic [7:0] timer_count_value;
  logic [7:0] timer_wrap_limit;
  wrap_timer_pkg::clock_cfg_type timer_clock_config;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic counter_halt;
  logic clear_armed;
  logic [7:0] prescaler;
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic fix_meta;
  logic fix_sync;
  logic fix_prev;
  logic src_tick;
  logic [7:0] ps_mask;
  logic advance;
  logic wrap_hit;
  logic bus_take;
  logic wr_take;
  logic rd_take;
  logic sel_status;
  logic sel_clock;
  logic sel_count;
  logic sel_wrap;
  logic clear_cmd;
  logic wrap_write;
  logic [7:0] read_mux;
  logic read_ok;
  logic ovf_since_read;

  // Address decoding
  always_comb begin
    sel_status = 1'b0;
    sel_clock = 1'b0;
    sel_count = 1'b0;
    sel_wrap = 1'b0;
    if (paddr[ADDR_W-1:0] == ADDR_W'(wrap_timer_pkg::OFF_STATUS)) begin
      sel_status = 1'b1;
    end else if (paddr[ADDR_W-1:0] == ADDR_W'(wrap_timer_pkg::OFF_CLOCK)) begin
      sel_clock = 1'b1;
    end else if (paddr[ADDR_W-1:0] == ADDR_W'(wrap_timer_pkg::OFF_COUNT)) begin
      sel_count = 1'b1;
    end else if (paddr[ADDR_W-1:0] == ADDR_W'(wrap_timer_pkg::OFF_WRAP)) begin
      sel_wrap = 1'b1;
    end
  end

  assign read_ok = sel_status | sel_clock | sel_count | sel_wrap;
  assign bus_take = psel & penable & pready;
  assign wr_take = bus_take & pwrite & ~pslverr;
  assign rd_take = bus_take & ~pwrite & ~pslverr;
  assign clear_cmd = wr_take & sel_status & pwdata[wrap_timer_pkg::BIT_CLEAR];
  assign wrap_write = wr_take & sel_wrap;

  always_comb begin
    read_mux = 8'h00;
    if (sel_status) begin
      read_mux = {overflow_flag, overflow_irq_enable, 1'b0, counter_halt, 4'h0};
    end else if (sel_clock) begin
      read_mux = {2'b00, timer_clock_config};
    end else if (sel_count) begin
      read_mux = timer_count_value;
    end else if (sel_wrap) begin
      read_mux = timer_wrap_limit;
    end
  end

  // APB answer, no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      if (psel & ~penable) begin
        pslverr <= ~read_ok;
        prdata <= {24'h00_0000, read_mux};
      end else if (bus_take) begin
        pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
      fix_meta <= 1'b0;
      fix_sync <= 1'b0;
      fix_prev <= 1'b0;
    end else begin
      ext_meta <= ext_count_input;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
      fix_meta <= fixed_freq_clock;
      fix_sync <= fix_meta;
      fix_prev <= fix_sync;
    end
  end

  always_comb begin
    case (timer_clock_config.source_select)
      wrap_timer_pkg::SRC_BUS: src_tick = 1'b1;
      wrap_timer_pkg::SRC_FIXED: src_tick = fix_sync & ~fix_prev;
      wrap_timer_pkg::SRC_EXT_FALL: src_tick = ext_prev & ~ext_sync;
      wrap_timer_pkg::SRC_EXT_RISE: src_tick = ext_sync & ~ext_prev;
      default: src_tick = 1'b1;
    endcase
  end

  always_comb begin
    if (timer_clock_config.prescale_select >= wrap_timer_pkg::PS_MAX) begin
      ps_mask = 8'hFF;
    end else begin
      ps_mask = 8'((9'h001 << timer_clock_config.prescale_select) - 9'h001);
    end
  end

  assign advance = src_tick & ~counter_halt & ~debug_active & ((prescaler & ps_mask) == ps_mask);
  assign wrap_hit = (timer_wrap_limit == 8'h00) ? (timer_count_value == wrap_timer_pkg::COUNT_TOP)
                                                : (timer_count_value == timer_wrap_limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescaler <= 8'h00;
    end else if (clear_cmd | wrap_write) begin
      prescaler <= 8'h00;
    end else if (src_tick & ~counter_halt & ~debug_active) begin
      prescaler <= (prescaler & ps_mask) == ps_mask ? 8'h00 : prescaler + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count_value <= wrap_timer_pkg::COUNT_RESET;
    end else if (clear_cmd | wrap_write) begin
      timer_count_value <= wrap_timer_pkg::COUNT_RESET;
    end else if (advance) begin
      timer_count_value <= wrap_hit ? wrap_timer_pkg::COUNT_RESET : timer_count_value + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq_enable <= wrap_timer_pkg::IRQ_EN_RESET;
      counter_halt <= wrap_timer_pkg::HALT_RESET;
      timer_clock_config <= wrap_timer_pkg::CLOCK_CFG_RESET;
      timer_wrap_limit <= wrap_timer_pkg::WRAP_RESET;
    end else if (wr_take) begin
      if (sel_status) begin
        overflow_irq_enable <= pwdata[wrap_timer_pkg::BIT_IRQ_EN];
        counter_halt <= pwdata[wrap_timer_pkg::BIT_HALT];
      end
      if (sel_clock) begin
        timer_clock_config <= wrap_timer_pkg::clock_cfg_type'(pwdata[5:0]);
      end
      if (sel_wrap) begin
        timer_wrap_limit <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
      clear_armed <= 1'b0;
    end else begin
      if (advance & wrap_hit) begin
        overflow_flag <= 1'b1;
        clear_armed <= 1'b0;
      end else if (clear_cmd | wrap_write) begin
        overflow_flag <= 1'b0;
        clear_armed <= 1'b0;
      end else if (wr_take & sel_status & ~pwdata[wrap_timer_pkg::BIT_OVERFLOW] & clear_armed) begin
        overflow_flag <= 1'b0;
        clear_armed <= 1'b0;
      end else if (rd_take & sel_status & prdata[wrap_timer_pkg::BIT_OVERFLOW]) begin
        clear_armed <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq <= 1'b0;
    end else begin
      overflow_irq <= overflow_flag & overflow_irq_enable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_since_read <= 1'b0;
    end else if (advance & wrap_hit) begin
      ovf_since_read <= 1'b1;
    end else if (rd_take & sel_status & prdata[wrap_timer_pkg::BIT_OVERFLOW]) begin
      ovf_since_read <= 1'b0;
    end
  end

  sequence seq_flag_read;
    rd_take && sel_status && prdata[7];
  endsequence

  sequence seq_zero_write;
    wr_take && sel_status && !pwdata[7] && !(advance && wrap_hit) && !ovf_since_read;
  endsequence

  AST_HALT_FREEZE: assert property (@(posedge pclk) disable iff (!presetn)
    counter_halt && !clear_cmd && !wrap_write |=> $stable(timer_count_value))
    else $error("Count moved while halted");

  AST_DEBUG_FREEZE: assert property (@(posedge pclk) disable iff (!presetn)
    debug_active && !clear_cmd && !wrap_write |=> $stable(timer_count_value))
    else $error("Count moved during debug");

  AST_CLEAR_CMD: assert property (@(posedge pclk) disable iff (!presetn)
    clear_cmd |=> timer_count_value == 8'h00)
    else $error("Clear command did not zero count");

  AST_WRAP_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wrap_write && !advance |=> timer_count_value == 8'h00 && !overflow_flag
      && timer_wrap_limit == $past(pwdata[7:0]))
    else $error("Wrap write effects missing");

  AST_WRAP_SET: assert property (@(posedge pclk) disable iff (!presetn)
    advance && wrap_hit && !clear_cmd && !wrap_write |=> overflow_flag && timer_count_value == 8'h00)
    else $error("Wrap did not set overflow");

  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    overflow_flag && overflow_irq_enable |=> overflow_irq)
    else $error("Interrupt not raised");

  AST_LOW_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    pready && psel && !pwrite && sel_status |-> prdata[3:0] == 4'h0 && prdata[5] == 1'b0)
    else $error("Unused status bits not zero");

  AST_TWO_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    seq_flag_read ##[1:300] seq_zero_write |=> !overflow_flag)
    else $error("Clearing sequence failed");

  AST_EXT_SINGLE: assert property (@(posedge pclk) disable iff (!presetn)
    timer_clock_config.source_select[1] && src_tick |=> !src_tick)
    else $error("Two ticks from one edge");

  AST_APB_READY: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("No ready after setup");

  AST_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !read_ok |=> pslverr)
    else $error("No error for unmapped address");

  AST_COUNT_RO: assert property (@(posedge pclk) disable iff (!presetn)
    wr_take && sel_count && !advance |=> $stable(timer_count_value))
    else $error("Count write took effect");

  AST_CFG_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    wr_take && sel_clock && !advance |=> $stable(timer_count_value))
    else $error("Clock config write changed count");

  AST_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    advance && !wrap_hit && !clear_cmd && !wrap_write
      |=> timer_count_value == $past(timer_count_value) + 8'h01)
    else $error("Count did not step by one");

  AST_FREE_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    advance && timer_wrap_limit == 8'h00 && !clear_cmd && !wrap_write
      |=> timer_count_value == $past(timer_count_value) + 8'h01)
    else $error("Free running count broke");

  AST_EXT_SYNC: assert property (@(posedge pclk) disable iff (!presetn)
    timer_clock_config.source_select == wrap_timer_pkg::SRC_EXT_RISE && src_tick
      |-> $past(ext_count_input, 2) && !$past(ext_count_input, 3))
    else $error("External edge not synchronised");

endmodule // wrap_timer

`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking APB bench for the modulo timer
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam logic [3:0] ST = wrap_timer_pkg::OFF_STATUS;
  localparam logic [3:0] CK = wrap_timer_pkg::OFF_CLOCK;
  localparam logic [3:0] CN = wrap_timer_pkg::OFF_COUNT;
  localparam logic [3:0] WR = wrap_timer_pkg::OFF_WRAP;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic ext_count_input, fixed_freq_clock, debug_active, overflow_irq;
  logic [3:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] q, c0;
  int error_cnt, checks, cyc, div;
  int pss[4] = '{0, 2, 8, 9};

  wrap_timer uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_count_input, .fixed_freq_clock, .debug_active, .overflow_irq);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task end_sim;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      end_sim();
    end
  end

  task chk(input logic [7:0] s, input logic [7:0] e);
    checks = checks + 1;
    if (s !== e) begin
      error_cnt = error_cnt + 1;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask

  // One APB transfer, held until pready
  task apb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task rc(input logic [3:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(q, e);
  endtask

  // Clear and start, run w cycles, halt, read count
  task run(input int w);
    wr(ST, 8'h20);
    repeat (w) @(posedge pclk);
    wr(ST, 8'h10);
    apb(1'b0, CN, 8'h00);
  endtask

  task pulse(input int n, input bit fx);
    repeat (n) begin
      @(posedge pclk);
      if (fx) fixed_freq_clock <= 1'b1;
      else ext_count_input <= 1'b1;
      repeat (4) @(posedge pclk);
      fixed_freq_clock <= 1'b0;
      ext_count_input <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask

  task src(input logic [7:0] cfg, input int n, input bit fx, input logic [7:0] e);
    wr(CK, cfg);
    wr(ST, 8'h20);
    pulse(n, fx);
    wr(ST, 8'h10);
    rc(CN, e);
  endtask

  // Config change while running keeps the count
  task keep(input logic [7:0] cfg);
    apb(1'b0, CN, 8'h00);
    c0 = q;
    wr(ST, 8'h00);
    wr(CK, cfg);
    wr(ST, 8'h10);
    apb(1'b0, CN, 8'h00);
    chk({7'h00, q >= c0 && q <= c0 + 8'h10}, 8'h01);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 4'h0;
    pwdata = 32'h00000000;
    ext_count_input = 1'b0;
    fixed_freq_clock = 1'b0;
    debug_active = 1'b0;
    error_cnt = 0;
    checks = 0;
    cyc = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rc(ST, 8'h10); // halted at reset
    rc(CK, 8'h00); // bus source
    rc(CN, 8'h00); // count zero
    rc(WR, 8'h00); // wrap zero
    wr(CK, 8'hFF);
    rc(CK, 8'h3F); // top bits zero
    wr(CN, 8'h55);
    rc(CN, 8'h00); // write ignored
    apb(1'b0, 4'h2, 8'h00);
    chk({7'h00, err}, 8'h01); // unmapped
    $display("registers done");
    wr(CK, 8'h00);
    wr(WR, 8'h04);
    wr(ST, 8'h40); // enable set with flag clear
    for (int i = 0; i < 60 && overflow_irq !== 1'b1; i++) @(posedge pclk);
    wr(ST, 8'h50);
    apb(1'b0, CN, 8'h00);
    c0 = q;
    chk({7'h00, c0 <= 8'h04}, 8'h01); // stays within wrap
    rc(CN, c0); // frozen
    rc(ST, 8'hD0); // set, no early clear
    chk({7'h00, overflow_irq}, 8'h01); // request up
    wr(ST, 8'h50);
    rc(ST, 8'h50); // cleared
    repeat (2) @(posedge pclk);
    chk({7'h00, overflow_irq}, 8'h00); // request down
    wr(WR, 8'h01);
    wr(ST, 8'h00);
    repeat (4) @(posedge pclk);
    rc(ST, 8'h80); // set again
    wr(ST, 8'h00);
    rc(ST, 8'h80); // overflow in between
    wr(ST, 8'h10);
    rc(ST, 8'h90); // still set after halt
    wr(WR, 8'h00);
    rc(ST, 8'h10); // wrap write clears
    wr(ST, 8'h00);
    repeat (200) @(posedge pclk);
    rc(ST, 8'h00); // no early wrap
    repeat (60) @(posedge pclk);
    rc(ST, 8'h80); // full range
    wr(ST, 8'h30);
    rc(CN, 8'h00); // count zeroed
    rc(ST, 8'h10); // reads zero
    $display("overflow done");
    foreach (pss[i]) begin
      wr(CK, 8'(pss[i]));
      div = pss[i] > 8 ? 256 : 1 << pss[i];
      run(10 * div - 4);
      chk({7'h00, q >= 8'h09 && q <= 8'h0B}, 8'h01); // division
    end
    keep(8'h00); // prescale change
    keep(8'h10); // source change
    $display("prescale done");
    src(8'h30, 5, 1'b0, 8'h05); // rising edges
    src(8'h31, 6, 1'b0, 8'h03); // divided
    src(8'h20, 3, 1'b0, 8'h03); // falling edges
    src(8'h10, 4, 1'b1, 8'h04); // fixed clock
    $display("sources done");
    wr(CK, 8'h00);
    wr(ST, 8'h20);
    repeat (5) @(posedge pclk);
    debug_active <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, CN, 8'h00);
    c0 = q;
    repeat (10) @(posedge pclk);
    rc(CN, c0); // suspended
    wr(ST, 8'h20);
    rc(CN, 8'h00); // clear in debug
    debug_active <= 1'b0;
    repeat (5) @(posedge pclk);
    apb(1'b0, CN, 8'h00);
    chk({7'h00, q > 8'h00}, 8'h01); // resumes
    $display("debug done");
    end_sim();
  end
endmodule // testbench

`default_nettype wire
